//--- mrt_defs.svh
`ifndef MRT_DEFS_SVH
`define MRT_DEFS_SVH
// memory type codes
`define MRT_TYPE_UC 8'h00
`define MRT_TYPE_WC 8'h01
`define MRT_TYPE_WT 8'h04
`define MRT_TYPE_WP 8'h05
`define MRT_TYPE_WB 8'h06
// default-type control fields
`define MRT_DEF_E_BIT 11
`define MRT_DEF_FE_BIT 10
`define MRT_DEF_TYPE_HI 7
`define MRT_DEF_MASK 32'h0000_0CFF
`define MRT_DEF_RESET 32'h0000_0000
// APB register map (byte addresses)
`define MRT_ADDR_DEF 12'h000
`define MRT_ADDR_CAP 12'h004
`define MRT_ADDR_FIX0 12'h040
`define MRT_ADDR_FIXN 12'h0A4
`define MRT_ADDR_FIXEND 12'h1A0
`define MRT_ADDR_VBASE0 12'h100
`define MRT_ADDR_VMASK0 12'h104
`define MRT_ADDR_VLAST 12'h13C
`define MRT_CAP_VALUE 32'h0000_0508
// fixed range geometry, in 4K pages of the first megabyte
`define MRT_PAGE_LSB 12
`define MRT_FIX_64K_END 8'h80
`define MRT_FIX_16K_END 8'hC0
`define MRT_FIX_64K_SH 4
`define MRT_FIX_16K_SH 2
`define MRT_FIX_16K_BASE 5'h08
`define MRT_FIX_4K_BASE 7'h18
`define MRT_NUM_FIX 88
`define MRT_NUM_VAR 8
`define MRT_VMASK_VALID 11
`endif

//--- mrt_pkg.sv
`default_nettype none
package mrt_pkg;
  typedef logic [7:0] mrt_type_t;
  // attribute bundle handed to the load/store path
  typedef struct packed {
    mrt_type_t mem_type;
    logic cacheable;
    logic write_combine;
    logic spec_read;
    logic spec_write;
    logic read_alloc;
    logic write_alloc;
    logic write_thru;
    logic write_protect;
  } mrt_attr_t;
  // fill line state request
  typedef enum logic [1:0] {
    MRT_LINE_I, MRT_LINE_S, MRT_LINE_E, MRT_LINE_M
  } mrt_line_t;
  // fill response from system
  typedef struct packed {
    logic valid;
    logic dirty;
    logic excl_ok;
    logic is_write;
  } mrt_fill_t;
endpackage : mrt_pkg
`default_nettype wire

//--- mrt_lookup.sv
`include "mrt_defs.svh"
`default_nettype none
module mrt_lookup (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [35:0] LOOKUP_ADDR,
  output mrt_pkg::mrt_attr_t LOOKUP_ATTR,
  input wire mrt_pkg::mrt_fill_t FILL_IN,
  output mrt_pkg::mrt_line_t FILL_STATE
);
  import mrt_pkg::*;

  // register storage
  logic [31:0] def_q;
  mrt_type_t fix_q [`MRT_NUM_FIX];
  logic [35:12] vbase_q [`MRT_NUM_VAR];
  mrt_type_t vtype_q [`MRT_NUM_VAR];
  logic [35:12] vmask_q [`MRT_NUM_VAR];
  logic vvalid_q [`MRT_NUM_VAR];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  mrt_line_t fill_q;

  // fixed entry index for a page number of the first megabyte
  function automatic logic [6:0] fix_index(input logic [7:0] pg);
    logic [6:0] r;
    r = 7'h00;
    if (pg < `MRT_FIX_64K_END) begin
      r = {3'h0, pg[7:`MRT_FIX_64K_SH]};
    end else if (pg < `MRT_FIX_16K_END) begin
      r = 7'(`MRT_FIX_16K_BASE) + {3'h0, pg[5:`MRT_FIX_16K_SH]};
    end else begin
      r = 7'(`MRT_FIX_4K_BASE + 7'(pg[5:0]));
    end
    return r;
  endfunction : fix_index

  // attribute decode for one memory type
  function automatic mrt_attr_t attr_of(input mrt_type_t t);
    mrt_attr_t a;
    a = '0;
    a.mem_type = t;
    if (t == `MRT_TYPE_WC) begin
      a.write_combine = 1'b1;
      a.spec_read = 1'b1;
    end else if (t == `MRT_TYPE_WT || t == `MRT_TYPE_WP) begin
      a.cacheable = 1'b1;
      a.spec_read = 1'b1;
      a.read_alloc = 1'b1;
      a.write_thru = 1'b1;
      a.write_protect = (t == `MRT_TYPE_WP);
    end else if (t == `MRT_TYPE_WB) begin
      a.cacheable = 1'b1;
      a.spec_read = 1'b1;
      a.read_alloc = 1'b1;
      a.write_alloc = 1'b1;
    end else begin
      a.mem_type = `MRT_TYPE_UC;
    end
    return a;
  endfunction : attr_of

  // variable range hits
  logic [`MRT_NUM_VAR-1:0] vhit;
  genvar gi;
  generate
    for (gi = 0; gi < `MRT_NUM_VAR; gi++) begin : g_var
      assign vhit[gi] = vvalid_q[gi] &&
        ((LOOKUP_ADDR[35:12] & vmask_q[gi]) == (vbase_q[gi] & vmask_q[gi]));
    end
  endgenerate

  // combinational resolution, same cycle as address
  mrt_type_t res_type;
  always_comb begin
    logic any_uc;
    logic any_wt;
    logic any_wb;
    logic any_other;
    logic low_mb;
    any_uc = 1'b0;
    any_wt = 1'b0;
    any_wb = 1'b0;
    any_other = 1'b0;
    low_mb = (LOOKUP_ADDR[35:20] == 16'h0000);
    for (int i = 0; i < `MRT_NUM_VAR; i++) begin
      if (vhit[i]) begin
        if (vtype_q[i] == `MRT_TYPE_UC) any_uc = 1'b1;
        else if (vtype_q[i] == `MRT_TYPE_WT) any_wt = 1'b1;
        else if (vtype_q[i] == `MRT_TYPE_WB) any_wb = 1'b1;
        else any_other = 1'b1;
      end
    end
    res_type = def_q[`MRT_DEF_TYPE_HI:0];
    if (!def_q[`MRT_DEF_E_BIT]) begin
      res_type = `MRT_TYPE_UC;
    end else if (def_q[`MRT_DEF_FE_BIT] && low_mb) begin
      res_type = fix_q[fix_index(LOOKUP_ADDR[19:12])];
    end else if (vhit != '0) begin
      res_type = `MRT_TYPE_UC;
      if (any_uc) res_type = `MRT_TYPE_UC;
      else if (any_wt && !any_other) res_type = `MRT_TYPE_WT;
      else if (any_wb && !any_other) res_type = `MRT_TYPE_WB;
      else begin
        for (int i = 0; i < `MRT_NUM_VAR; i++) begin
          if (vhit[i]) res_type = vtype_q[i];
        end
      end
    end
  end

  // attribute output is combinational so the pipeline sees it this cycle
  assign LOOKUP_ATTR = attr_of(res_type);

  // fill line state: write-back by response, write-through and write-protect shared on reads only
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fill_q <= MRT_LINE_I;
    end else if (FILL_IN.valid) begin
      if (res_type == `MRT_TYPE_WB) begin
        if (FILL_IN.is_write) fill_q <= FILL_IN.excl_ok ? MRT_LINE_M : MRT_LINE_S;
        else fill_q <= FILL_IN.dirty ? MRT_LINE_M : MRT_LINE_S;
      end else if ((res_type == `MRT_TYPE_WT || res_type == `MRT_TYPE_WP) &&
                   !FILL_IN.is_write) begin
        fill_q <= MRT_LINE_S;
      end else begin
        fill_q <= MRT_LINE_I;
      end
    end
  end
  assign FILL_STATE = fill_q;

  // apb decode helpers
  logic wr_en;
  logic rd_en;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;

  // default control register
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      def_q <= `MRT_DEF_RESET;
    end else if (wr_en && PADDR == `MRT_ADDR_DEF) begin
      def_q <= PWDATA & `MRT_DEF_MASK;
    end
  end

  // fixed entries, one per word
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < `MRT_NUM_FIX; i++) fix_q[i] <= `MRT_TYPE_UC;
    end else if (wr_en && PADDR >= `MRT_ADDR_FIX0 && PADDR < `MRT_ADDR_FIXEND
                 && PADDR[1:0] == 2'h0) begin
      fix_q[7'((PADDR - `MRT_ADDR_FIX0) >> 2)] <= PWDATA[7:0];
    end
  end

  // variable range base and mask pairs
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < `MRT_NUM_VAR; i++) begin
        vbase_q[i] <= '0;
        vtype_q[i] <= `MRT_TYPE_UC;
        vmask_q[i] <= '0;
        vvalid_q[i] <= 1'b0;
      end
    end else if (wr_en && PADDR >= `MRT_ADDR_VBASE0 && PADDR <= `MRT_ADDR_VLAST) begin
      if (!PADDR[2]) begin
        vbase_q[PADDR[5:3]] <= {4'h0, PWDATA[31:12]};
        vtype_q[PADDR[5:3]] <= PWDATA[7:0];
      end else begin
        vmask_q[PADDR[5:3]] <= {4'hF, PWDATA[31:12]};
        vvalid_q[PADDR[5:3]] <= PWDATA[`MRT_VMASK_VALID];
      end
    end
  end

  // read data, ready and error answer in the access phase
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= PSEL && !PENABLE;
      pslverr_q <= 1'b0;
      if (PSEL && !PENABLE) begin
        prdata_q <= '0;
        if (PADDR == `MRT_ADDR_DEF) begin
          prdata_q <= def_q;
        end else if (PADDR == `MRT_ADDR_CAP) begin
          prdata_q <= `MRT_CAP_VALUE;
        end else if (PADDR >= `MRT_ADDR_VBASE0 && PADDR <= `MRT_ADDR_VLAST) begin
          // variable pairs win the shared read window
          if (!PADDR[2]) prdata_q <= {vbase_q[PADDR[5:3]][31:12], 4'h0, vtype_q[PADDR[5:3]]};
          else prdata_q <= {vmask_q[PADDR[5:3]][31:12], vvalid_q[PADDR[5:3]], 11'h000};
        end else if (PADDR >= `MRT_ADDR_FIX0 && PADDR < `MRT_ADDR_FIXEND) begin
          prdata_q <= {24'h0, fix_q[7'((PADDR - `MRT_ADDR_FIX0) >> 2)]};
        end else begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  wire unused_ok = rd_en;
endmodule : mrt_lookup
`default_nettype wire

//--- mrt_lookup_monitor.sv
`include "mrt_defs.svh"
`default_nettype none
module mrt_lookup_monitor (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire mrt_pkg::mrt_attr_t LOOKUP_ATTR,
  input wire mrt_pkg::mrt_fill_t FILL_IN,
  input wire mrt_pkg::mrt_line_t FILL_STATE
);
  timeunit 1ns;
  timeprecision 1ns;
  import mrt_pkg::*;
  logic en_q;
  mrt_attr_t a;
  mrt_type_t t;
  assign a = LOOKUP_ATTR;
  assign t = LOOKUP_ATTR.mem_type;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // global enable as last written
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
      en_q <= 1'h0;
    else if (PSEL && PENABLE && PWRITE && PREADY && PADDR == `MRT_ADDR_DEF)
      en_q <= PWDATA[`MRT_DEF_E_BIT];
  end
  AST_OFF_UC: assert property (!en_q |-> t == `MRT_TYPE_UC)
    else $error("type not uc while off");
  AST_UC: assert property (t == `MRT_TYPE_UC |-> !a.cacheable && !a.write_combine && !a.spec_read)
    else $error("uc attr wrong");
  AST_WC: assert property (t == `MRT_TYPE_WC |-> !a.cacheable && a.write_combine && a.spec_read && !a.spec_write)
    else $error("wc attr wrong");
  AST_WT: assert property (t == `MRT_TYPE_WT |-> a.cacheable && a.read_alloc && !a.write_alloc)
    else $error("wt attr wrong");
  AST_WP: assert property (t == `MRT_TYPE_WP |-> a.cacheable && a.write_protect && !a.write_alloc)
    else $error("wp attr wrong");
  AST_WB_READ: assert property (FILL_IN.valid && !FILL_IN.is_write && t == `MRT_TYPE_WB |=>
    FILL_STATE == ($past(FILL_IN.dirty) ? MRT_LINE_M : MRT_LINE_S)) else $error("wb read fill");
  AST_WB_WRITE: assert property (FILL_IN.valid && FILL_IN.is_write && t == `MRT_TYPE_WB |=>
    FILL_STATE == ($past(FILL_IN.excl_ok) ? MRT_LINE_M : MRT_LINE_S)) else $error("wb write fill");
  AST_WT_READ: assert property (FILL_IN.valid && !FILL_IN.is_write &&
    (t == `MRT_TYPE_WT || t == `MRT_TYPE_WP) |=> FILL_STATE == MRT_LINE_S) else $error("wt fill");
  cover property (FILL_IN.valid && FILL_IN.dirty);
  cover property (t == `MRT_TYPE_WC);
  cover property (PSEL && PENABLE && PWRITE && PREADY);
endmodule : mrt_lookup_monitor
`default_nettype wire

//--- mrt_cpu_model.sv
`default_nettype none
module mrt_cpu_model (
  input wire logic CLK,
  input wire logic [35:0] req_addr,
  input wire mrt_pkg::mrt_fill_t req_fill,
  output logic [35:0] addr,
  output mrt_pkg::mrt_fill_t fill
);
  timeunit 1ns;
  timeprecision 1ns;
  import mrt_pkg::*;
  // address first, attr used that cycle; idle fill bits toggle
  always_ff @(posedge CLK) begin
    addr <= req_addr;
    fill <= req_fill.valid ? req_fill : {1'h0, ~fill[2:0]};
  end
endmodule : mrt_cpu_model
`default_nettype wire

//--- mrt_lookup_tb.sv
`include "mrt_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mrt_pkg::*;
  logic CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [35:0] LOOKUP_ADDR, req_addr;
  mrt_attr_t LOOKUP_ATTR;
  mrt_fill_t FILL_IN, req_fill;
  mrt_line_t FILL_STATE;
  int bad_count, total_checks, cyc;
  logic [7:0] ty [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
  mrt_lookup u_mrt_lookup (.CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .LOOKUP_ADDR, .LOOKUP_ATTR, .FILL_IN, .FILL_STATE);
  mrt_cpu_model u_mrt_cpu_model (.CLK, .req_addr, .req_fill, .addr(LOOKUP_ADDR), .fill(FILL_IN));
  initial begin
    CLK = 1'h0;
    forever #20 CLK = ~CLK;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until ready
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'h1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    do @(posedge CLK); while (PREADY !== 1'h1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge CLK);
  endtask : apb
  task look(input logic [35:0] a, input logic [7:0] t);
    req_addr <= a;
    repeat (2) @(posedge CLK);
    chk({24'h0, LOOKUP_ATTR.mem_type}, {24'h0, t});
  endtask : look
  task fill(input logic [2:0] f, input mrt_line_t s);
    req_fill <= {1'h1, f};
    @(posedge CLK);
    req_fill.valid <= 1'h0;
    repeat (2) @(posedge CLK);
    chk({30'h0, FILL_STATE}, {30'h0, s});
  endtask : fill
  // hang guard
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      stop_test;
    end
  end
  initial begin
    SYS_RST = 1'h1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    req_addr = '0;
    req_fill = '0;
    repeat (5) @(posedge CLK);
    SYS_RST <= 1'h0;
    @(posedge CLK);
    apb(0, `MRT_ADDR_DEF, 0);
    chk(rd, 32'h0);
    look(36'h1000, 8'h00);
    apb(0, 12'hFFC, 0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    apb(1, `MRT_ADDR_FIX0, 6);
    apb(1, 12'h0A0, 5);
    apb(1, `MRT_ADDR_VBASE0, 4);
    apb(1, `MRT_ADDR_VMASK0, 32'hFFF0_0800);
    apb(1, 12'h108, 32'h0010_0006);
    apb(1, 12'h10C, 32'hFFF0_0800);
    apb(1, `MRT_ADDR_DEF, 32'hC01);
    look(36'hFFFF, 8'h06);
    look(36'h1_0000, 8'h00);
    look(36'hC_0000, 8'h05);
    look(36'hC_1000, 8'h00);
    look(36'h18_0000, 8'h06);
    look(36'h40_0000, 8'h01);
    apb(1, `MRT_ADDR_DEF, 32'h801);
    look(36'hFFFF, 8'h04);
    apb(1, `MRT_ADDR_DEF, 32'h001);
    look(36'h18_0000, 8'h00);
    $display("test priority done");
    apb(1, `MRT_ADDR_DEF, 32'h801);
    apb(1, 12'h108, 6);
    look(36'h1000, 8'h04);
    apb(1, 12'h108, 0);
    look(36'h1000, 8'h00);
    apb(1, 12'h108, 4);
    look(36'h1000, 8'h04);
    $display("test overlap done");
    foreach (ty[i]) begin
      apb(1, `MRT_ADDR_DEF, {24'h8, ty[i]});
      look(36'h40_0000, ty[i]);
    end
    fill(3'h4, MRT_LINE_M);
    fill(3'h0, MRT_LINE_S);
    fill(3'h3, MRT_LINE_M);
    fill(3'h1, MRT_LINE_S);
    apb(1, `MRT_ADDR_DEF, 32'h804);
    fill(3'h0, MRT_LINE_S);
    fill(3'h1, MRT_LINE_I);
    $display("test types done");
    stop_test;
  end
endmodule : testbench
bind mrt_lookup mrt_lookup_monitor u_mrt_lookup_monitor (.CLK, .SYS_RST, .PSEL, .PENABLE,
  .PWRITE, .PREADY, .PADDR, .PWDATA, .LOOKUP_ATTR, .FILL_IN, .FILL_STATE);
`default_nettype wire
